// ### common/asp_pkg.sv
// Package for the asynchronous serial port: register map, field positions,
// reset values, sequencing counts and state encodings.
// Assumes one clock (aclk) that plays the part of the oscillator.
package asp_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses on AXI4-Lite)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;  // serial_control
	localparam logic [7:0] OFS_BUF  = 8'h04;  // serial_buffer
	localparam logic [7:0] OFS_BAUD = 8'h08;  // baud_doubler
	localparam logic [7:0] OFS_STAT = 8'h0C;  // busy status

	// serial_control fields, then baud_doubler and status bits
	localparam int CTRL_RX_DONE  = 0;  // rx_done_flag
	localparam int CTRL_TX_DONE  = 1;  // tx_done_flag
	localparam int CTRL_RX_NINTH = 2;  // rx_ninth_bit
	localparam int CTRL_TX_NINTH = 3;  // tx_ninth_bit
	localparam int CTRL_REN      = 4;  // receive allow
	localparam int CTRL_FILTER   = 5;  // multiproc_filter
	localparam int CTRL_MODE     = 6;  // mode field, two bits
	localparam int BAUD_DBL  = 0;  // baud_doubler
	localparam int STAT_TXB  = 0;  // transmitter busy
	localparam int STAT_RXB  = 1;  // receiver busy

	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic       DBL_RST  = 1'b0;

	// Frame modes
	localparam logic [1:0] MODE_SHIFT = 2'b00;  // not implemented here
	localparam logic [1:0] MODE_10    = 2'b01;
	localparam logic [1:0] MODE_11F   = 2'b10;
	localparam logic [1:0] MODE_11V   = 2'b11;

	// Sequencing counts
	localparam logic [3:0] MC_LAST   = 4'hB;    // twelve clocks per machine cycle
	localparam logic [3:0] DIV_LAST  = 4'hF;    // divide-by-16 rollover state
	localparam logic [3:0] SAMP_A    = 4'h7;
	localparam logic [3:0] SAMP_B    = 4'h8;
	localparam logic [3:0] SAMP_C    = 4'h9;
	localparam logic [8:0] RX_FILL   = 9'h1FF;
	localparam logic [7:0] TX_MARK   = 8'h01;   // end marker pattern above output bit
	localparam logic [1:0] PRE_SLOW  = 2'h3;    // 16x tick every 4 clocks
	localparam logic [1:0] PRE_FAST  = 2'h1;    // 16x tick every 2 clocks
	localparam logic [3:0] STEPS_10  = 4'hA;
	localparam logic [3:0] STEPS_11  = 4'hB;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'b001,
		TX_START = 3'b010,
		TX_DATA  = 3'b100
	} asp_tx_e;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_RUN  = 3'b010,
		RX_STOP = 3'b100
	} asp_rx_e;

endpackage

// ### core/asp_rate_gen.sv
// 16x bit-rate tick generator for the serial port.
// Assumes t1_overflow is a one-clock pulse from timer logic on aclk.
`timescale 1ns/1ps
module asp_rate_gen (
	input  wire logic aclk,         // Oscillator clock
	input  wire logic aresetn,      // Synchronous reset, active low
	input  wire logic fixed_rate,   // Fixed-rate eleven-bit mode selected
	input  wire logic doubler,      // baud_doubler
	input  wire logic t1_overflow,  // Timer 1 overflow pulse
	output logic      tick16        // One pulse per 1/16 bit time
);
	import asp_pkg::*;

	typedef struct packed {
		logic [1:0] presc;
		logic       half;
		logic       tick;
	} asp_rg_s;

	asp_rg_s s;
	asp_rg_s next_s;

	// ----------------------------------------------------------------
	// Rate selection
	// ----------------------------------------------------------------
	// Fixed mode: bit rate osc/64 or osc/32, so the 16x tick is osc/4 or osc/2
	always_comb begin
		next_s      = s;
		next_s.tick = 1'b0;
		if (fixed_rate) begin
			if (s.presc >= (doubler ? PRE_FAST : PRE_SLOW)) begin  // R8 R20
				next_s.presc = 2'h0;
				next_s.tick  = 1'b1;
			end else begin
				next_s.presc = s.presc + 2'h1;
			end
		end else if (t1_overflow) begin
			// Timer rate: bit = 2^dbl/32 * overflow, so 16x tick = overflow / (2 - dbl)
			next_s.presc = 2'h0;
			next_s.half  = ~s.half;
			next_s.tick  = doubler | s.half;  // R2 R21
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign tick16 = s.tick;

	chk_slow_spacing: assert property (@(posedge aclk) disable iff (!aresetn)  // R20
		(s.tick && fixed_rate && !doubler) ##1 (fixed_rate && !doubler) [*2]
		|=> (!s.tick && !$past(s.tick) && !$past(s.tick, 2)))
		else $error("fixed slow rate tick spacing below four clocks");
endmodule

// ### core/asp_rx_sampler.sv
// Receive pin synchroniser and falling-edge detector at the 16x rate.
// Assumes rx_pin is asynchronous to aclk.
`timescale 1ns/1ps
module asp_rx_sampler (
	input  wire logic aclk,      // Oscillator clock
	input  wire logic aresetn,   // Synchronous reset, active low
	input  wire logic rx_pin,    // Raw receive pin
	input  wire logic tick16,    // 16x sampling tick
	output logic      rx_level,  // Synchronised pin level
	output logic      rx_fall    // High-to-low seen at a 16x tick
);
	import asp_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic prev;
		logic fall;
	} asp_rs_s;

	asp_rs_s s;
	asp_rs_s next_s;

	// ----------------------------------------------------------------
	// Synchroniser and edge search
	// ----------------------------------------------------------------
	// Only s2 is looked at; s1 feeds s2 alone to keep metastability contained
	always_comb begin
		next_s      = s;
		next_s.s1   = rx_pin;
		next_s.s2   = s.s1;
		next_s.fall = tick16 & s.prev & ~s.s2;  // R10
		if (tick16)
			next_s.prev = s.s2;
	end

	// Line idles high, so reset to ones to avoid a false edge
	always_ff @(posedge aclk) begin
		if (!aresetn)
			s <= 4'b1110;
		else
			s <= next_s;
	end

	assign rx_level = s.s2;
	assign rx_fall  = s.fall;

	chk_fall_cause: assert property (@(posedge aclk) disable iff (!aresetn)  // R10
		s.fall |-> ($past(tick16) && !$past(s.s2) && $past(s.prev)))
		else $error("falling edge flagged without a high-to-low sample");
endmodule

// ### core/asp_serial_port.sv
// Asynchronous serial port, ten-bit and eleven-bit frame modes, AXI4-Lite slave.
// Assumes aclk is the oscillator and t1_overflow comes from timer logic on aclk.
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
// Function
// R1: Ten-bit frame: start, eight LSB-first, stop
// R2: Ten-bit mode rate comes from timer 1
// R3: Buffer write loads shifter, marker 1 ninth
// R4: Start at cycle start after next rollover
// R5: Start bit, then data, then shifting
// R6: Ten-bit: zeros fill, done at tenth rollover
// R7: Eleven-bit frame adds programmed ninth bit
// R8: Fixed mode osc/32 or /64; other timer
// R9: Eleven-bit: ninth loaded, done at eleventh
// R10: Falling edge restarts counter, fills ones
// R11: Majority of samples seven, eight, nine
// R12: Non-low start bit resets the receiver
// R13: Ten-bit load gated by flag and filter
// R14: Failed frame dropped; search resumes anyway
// R15: Eleven-bit load gated by ninth bit
// R16: Stop ignored; resume one bit later
// R17: Interrupt is OR of both done flags
// R18: Software flag writes act like hardware
// R19: Start recognised only with receive allowed
// R20: Fixed mode: doubler 0 slow, 1 fast
// R21: Timer rate scales by doubler over 32
// R22: Counter steps per tick, rollover bit boundary
// R23: Machine cycle of twelve oscillator clocks
module asp_serial_port (
	input  wire logic        aclk,           // Oscillator clock, 25 MHz
	input  wire logic        aresetn,        // Synchronous reset, active low
	input  wire logic [7:0]  s_axi_awaddr,   // Write address
	input  wire logic        s_axi_awvalid,  // Write address valid
	output logic             s_axi_awready,  // Write address ready
	input  wire logic [31:0] s_axi_wdata,    // Write data
	input  wire logic [3:0]  s_axi_wstrb,    // Write strobes
	input  wire logic        s_axi_wvalid,   // Write data valid
	output logic             s_axi_wready,   // Write data ready
	output logic [1:0]       s_axi_bresp,    // Write response
	output logic             s_axi_bvalid,   // Write response valid
	input  wire logic        s_axi_bready,   // Write response ready
	input  wire logic [7:0]  s_axi_araddr,   // Read address
	input  wire logic        s_axi_arvalid,  // Read address valid
	output logic             s_axi_arready,  // Read address ready
	output logic [31:0]      s_axi_rdata,    // Read data
	output logic [1:0]       s_axi_rresp,    // Read response
	output logic             s_axi_rvalid,   // Read data valid
	input  wire logic        s_axi_rready,   // Read data ready
	input  wire logic        t1_overflow,    // Timer 1 overflow pulse
	input  wire logic        rx_pin,         // Receive pin
	output logic             tx_pin,         // Transmit pin
	output logic             serial_irq      // Serial interrupt request
);
	import asp_pkg::*;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic        aw_got;
		logic        w_got;
		logic [7:0]  waddr;
		logic [7:0]  wdata;
		logic        wlane;
		logic [1:0]  mode;
		logic        filter;
		logic        ren;
		logic        tx_ninth_bit;
		logic        rx_ninth_bit;
		logic        tx_done_flag;
		logic        rx_done_flag;
		logic        dbl;
		logic [7:0]  rxbuf;
		logic [3:0]  cyc;
		asp_tx_e     tx_state;
		logic [8:0]  tx_sh;
		logic        tx_first;
		logic        tx_req;
		logic        tx_pend;
		logic [3:0]  tx_div;
		logic [3:0]  tx_steps;
		logic        txd;
		asp_rx_e     rx_state;
		logic [3:0]  rx_div;
		logic [8:0]  rx_sh;
		logic        rx_first;
		logic [2:0]  samp;
		logic        irq;
	} asp_sp_s;

	asp_sp_s s;
	asp_sp_s next_s;

	logic tick16;
	logic rx_level;
	logic rx_fall;
	logic do_wr;
	logic wr_ctrl;
	logic wr_buf;
	logic cyc_start;
	logic tx_roll;
	logic tx_step;
	logic tx_end;
	logic set_tx_done;
	logic set_rx_done;
	logic rx_roll;
	logic rx_bit;
	logic rx_start;
	logic rx_final;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Aligned, in-range word addresses only
	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a[1:0] == 2'b00) && (a <= OFS_STAT);
	endfunction

	function automatic logic majority(input logic [2:0] v);
		majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	// ----------------------------------------------------------------
	// Rate source and receive pin front end
	// ----------------------------------------------------------------
	asp_rate_gen u_rate (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.fixed_rate  (s.mode == MODE_11F),
		.doubler     (s.dbl),
		.t1_overflow (t1_overflow),
		.tick16      (tick16)
	);

	asp_rx_sampler u_rxs (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.rx_pin   (rx_pin),
		.tick16   (tick16),
		.rx_level (rx_level),
		.rx_fall  (rx_fall)
	);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		set_tx_done = 1'b0;
		set_rx_done = 1'b0;
		rx_final = 1'b0;

		// Write channel: address and data taken in either order
		if (s.awready && s_axi_awvalid) begin
			next_s.aw_got = 1'b1;
			next_s.waddr  = s_axi_awaddr;
		end
		if (s.wready && s_axi_wvalid) begin
			next_s.w_got = 1'b1;
			next_s.wdata = s_axi_wdata[7:0];
			next_s.wlane = s_axi_wstrb[0];
		end
		if (s.bvalid && s_axi_bready)
			next_s.bvalid = 1'b0;
		do_wr = s.aw_got && s.w_got && !s.bvalid;
		if (do_wr) begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = addr_hit(s.waddr) ? RESP_OKAY : RESP_SLVERR;
		end
		next_s.awready = !next_s.aw_got && !next_s.bvalid;
		next_s.wready  = !next_s.w_got && !next_s.bvalid;
		wr_ctrl = do_wr && s.wlane && (s.waddr == OFS_CTRL);
		wr_buf  = do_wr && s.wlane && (s.waddr == OFS_BUF);
		if (do_wr && s.wlane && (s.waddr == OFS_BAUD))
			next_s.dbl = s.wdata[BAUD_DBL];

		// Read channel: one read outstanding, data muxed at the address edge
		if (s.rvalid && s_axi_rready)
			next_s.rvalid = 1'b0;
		if (s.arready && s_axi_arvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			next_s.rdata  = 32'h0000_0000;
			unique case (s_axi_araddr)
				OFS_CTRL: next_s.rdata[7:0] = {s.mode, s.filter, s.ren, s.tx_ninth_bit,
					s.rx_ninth_bit, s.tx_done_flag, s.rx_done_flag};
				OFS_BUF:  next_s.rdata[7:0] = s.rxbuf;
				OFS_BAUD: next_s.rdata[BAUD_DBL] = s.dbl;
				// A queued frame counts as busy, so the flag rises with the buffer write
				OFS_STAT: next_s.rdata[STAT_RXB:STAT_TXB] = {s.rx_state != RX_IDLE, (s.tx_state != TX_IDLE) || s.tx_req};
				default:  next_s.rdata = 32'h0000_0000;
			endcase
		end
		next_s.arready = !next_s.rvalid;

		// Machine cycle of twelve clocks; step phases hang off its first clock
		next_s.cyc = (s.cyc == MC_LAST) ? 4'h0 : s.cyc + 4'h1;  // R23
		cyc_start  = (s.cyc == 4'h0);

		// Transmit divide-by-16: each rollover is a bit boundary
		tx_roll = tick16 && (s.tx_div == DIV_LAST);  // R22
		if (tick16)
			next_s.tx_div = s.tx_div + 4'h1;
		if (tx_roll)
			next_s.tx_pend = 1'b1;
		tx_step = cyc_start && s.tx_pend;  // R4
		if (tx_step)
			next_s.tx_pend = 1'b0;
		if (tx_step && s.tx_state != TX_IDLE)
			next_s.tx_steps = s.tx_steps + 4'h1;

		// Transmit sequencer
		tx_end = (s.tx_sh[8:1] == TX_MARK) && ((s.mode == MODE_10) || !s.tx_first);
		unique case (s.tx_state)
			TX_IDLE: begin
				if (tx_step && s.tx_req) begin
					next_s.tx_req   = 1'b0;
					next_s.tx_state = TX_START;
					next_s.txd      = 1'b0;  // R1 R5 R7
					next_s.tx_steps = 4'h1;
				end
			end
			TX_START: begin
				if (tx_step) begin
					next_s.tx_state = TX_DATA;
					next_s.txd      = s.tx_sh[0];  // R5
				end
			end
			TX_DATA: begin
				if (tx_step) begin
					if (tx_end) begin
						// Final step drives the stop bit high on the line without shifting
						next_s.tx_state = TX_IDLE;
						next_s.txd      = 1'b1;  // R6 R9
						set_tx_done     = 1'b1;
					end else begin
						// Eleven-bit first shift inserts the stop bit, then zeros
						next_s.tx_sh    = {(s.mode != MODE_10) && s.tx_first, s.tx_sh[8:1]};  // R6 R9
						next_s.tx_first = 1'b0;
						next_s.txd      = s.tx_sh[1];
					end
				end
			end
		endcase

		// Buffer write: ignored while a frame is queued or under way
		if (wr_buf && (s.tx_state == TX_IDLE) && !s.tx_req && (s.mode != MODE_SHIFT)) begin
			next_s.tx_sh    = {(s.mode == MODE_10) ? 1'b1 : s.tx_ninth_bit, s.wdata};  // R3 R9
			next_s.tx_req   = 1'b1;
			next_s.tx_first = 1'b1;
			next_s.tx_pend  = 1'b0;  // R4
		end

		// Receive bit timing and voting
		rx_roll  = tick16 && (s.rx_div == DIV_LAST);
		rx_bit   = majority(s.samp);  // R11
		rx_start = (s.rx_state == RX_IDLE) && rx_fall && s.ren && (s.mode != MODE_SHIFT);  // R19
		if (tick16)
			next_s.rx_div = s.rx_div + 4'h1;
		if (tick16) begin
			unique case (s.rx_div)
				SAMP_A:  next_s.samp[0] = rx_level;  // R11
				SAMP_B:  next_s.samp[1] = rx_level;
				SAMP_C:  next_s.samp[2] = rx_level;
				default: next_s.samp = s.samp;
			endcase
		end

		unique case (s.rx_state)
			RX_IDLE: begin
				if (rx_start) begin
					next_s.rx_div   = 4'h0;  // R10
					next_s.rx_sh    = RX_FILL;
					next_s.rx_first = 1'b1;
					next_s.rx_state = RX_RUN;
				end
			end
			RX_RUN: begin
				if (rx_roll) begin
					next_s.rx_sh = {rx_bit, s.rx_sh[8:1]};
					if (s.rx_first) begin
						next_s.rx_first = 1'b0;
						if (rx_bit)
							next_s.rx_state = RX_IDLE;  // R12
					end else if (!s.rx_sh[0]) begin
						// Start bit has reached the end: this is the final shift
						rx_final = 1'b1;
						if (!s.rx_done_flag && (!s.filter || rx_bit)) begin  // R13 R15
							next_s.rxbuf = s.rx_sh[8:1];
							set_rx_done  = 1'b1;
						end
						next_s.rx_state = (s.mode == MODE_10) ? RX_IDLE : RX_STOP;  // R14 R16
					end
				end
			end
			RX_STOP: begin
				if (rx_roll)
					next_s.rx_state = RX_IDLE;  // R16
			end
		endcase

		// Control register; hardware set beats a same-cycle software clear
		if (wr_ctrl) begin
			next_s.mode   = s.wdata[CTRL_MODE +: 2];
			next_s.filter       = s.wdata[CTRL_FILTER];
			next_s.ren          = s.wdata[CTRL_REN];
			next_s.tx_ninth_bit = s.wdata[CTRL_TX_NINTH];
			next_s.rx_ninth_bit = s.wdata[CTRL_RX_NINTH];
		end
		next_s.tx_done_flag = (wr_ctrl ? s.wdata[CTRL_TX_DONE] : s.tx_done_flag) | set_tx_done;  // R18
		next_s.rx_done_flag = (wr_ctrl ? s.wdata[CTRL_RX_DONE] : s.rx_done_flag) | set_rx_done;  // R18
		if (set_rx_done)
			next_s.rx_ninth_bit = rx_bit;  // R1 R15
		next_s.irq = next_s.tx_done_flag | next_s.rx_done_flag;  // R17
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s          <= '0;
			s.tx_state <= TX_IDLE;
			s.rx_state <= RX_IDLE;
			s.txd      <= 1'b1;
			s.rx_sh    <= RX_FILL;
			s.dbl      <= DBL_RST;
			{s.mode, s.filter, s.ren, s.tx_ninth_bit, s.rx_ninth_bit, s.tx_done_flag, s.rx_done_flag} <= CTRL_RST;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready  = s.wready;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rresp   = s.rresp;
	assign s_axi_rdata   = s.rdata;
	assign tx_pin        = s.txd;
	assign serial_irq    = s.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence seq_tx_launch;
		s.tx_state == TX_IDLE && tx_step && s.tx_req;
	endsequence

	chk_irq_or: assert property (serial_irq == (s.tx_done_flag || s.rx_done_flag))  // R17
		else $error("interrupt request differs from done flags");
	chk_tx_start_bit: assert property (seq_tx_launch |=> (!tx_pin && s.tx_state == TX_START))  // R5
		else $error("start bit not driven at launch");
	chk_tx_cycle_align: assert property (tx_step |-> s.cyc == 4'h0)  // R4
		else $error("transmit step off the machine cycle start");
	chk_tx_frame_len: assert property (set_tx_done |->  // R6
		(s.tx_steps + 4'h1) == ((s.mode == MODE_10) ? STEPS_10 : STEPS_11))
		else $error("transmit done at wrong rollover count");
	chk_tx_done_flag: assert property (set_tx_done |=> (s.tx_done_flag && tx_pin && s.tx_state == TX_IDLE))  // R9
		else $error("transmit end did not set flag and idle line");
	chk_rx_fill: assert property (rx_start |=> (s.rx_sh == RX_FILL && s.rx_div == 4'h0))  // R10
		else $error("receiver not restarted on edge");
	chk_rx_enable: assert property ($rose(s.rx_state == RX_RUN) |-> $past(s.ren))  // R19
		else $error("receive started while not allowed");
	chk_rx_false_start: assert property ((s.rx_state == RX_RUN && rx_roll && s.rx_first && rx_bit)
		|=> s.rx_state == RX_IDLE)  // R12
		else $error("false start bit not rejected");
	chk_rx_load_gate: assert property (set_rx_done |-> (!s.rx_done_flag && (!s.filter || rx_bit))  // R13
		##1 (s.rx_done_flag && s.rx_ninth_bit == $past(rx_bit)))
		else $error("receive load despite gating");
	chk_rx_drop: assert property ((rx_final && s.rx_done_flag) |=> $stable(s.rxbuf))  // R14
		else $error("buffer changed on a dropped frame");
endmodule

// ### tb/asp_remote_node.sv
// Remote serial node: sends frames to the port and records what the port sends.
// Assumes the bench sets the bit length in clocks; the line into the port idles high.
`timescale 1ns/1ps
module asp_remote_node (
	input  wire logic       aclk,      // Bench clock
	input  wire logic       tx_line,   // From the port transmit pin
	input  wire logic [7:0] bit_clks,  // Clocks per bit
	output logic            rx_line    // To the port receive pin
);
	logic [10:0] got_q[$];  // Frames seen, first bit in bit 0

	initial rx_line = 1'b1;

	// ----------------------------------------------------------------
	// Stimulus toward the port
	// ----------------------------------------------------------------
	// Send n bits, first bit first; the released line is pulled high
	task automatic send(input logic [10:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			rx_line <= f[i];
			repeat (bit_clks) @(posedge aclk);
		end
		rx_line <= 1'b1;
	endtask

	// Short low pulse, too short to pass the start-bit vote
	task automatic glitch(input int c);
		rx_line <= 1'b0;
		repeat (c) @(posedge aclk);
		rx_line <= 1'b1;
	endtask

	// ----------------------------------------------------------------
	// Capture from the port
	// ----------------------------------------------------------------
	// Sample mid-bit; eleven samples cover either frame, idle reads high
	always @(negedge tx_line) begin
		logic [10:0] f;
		repeat (bit_clks / 2) @(posedge aclk);
		for (int i = 0; i < 11; i++) begin
			f[i] = tx_line;
			repeat (bit_clks) @(posedge aclk);
		end
		got_q.push_back(f);
	end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the serial port: register model plus remote node.
// Assumes timer overflow every second clock, so bit length is 32 or 64 clocks.
`timescale 1ns/1ps
module tb_top;
	import asp_pkg::*;
	logic        aclk, aresetn, awv, wv, bre, arv, rre, t1;
	logic [7:0]  awa, ara, blen, m_ctl, m_buf;
	logic [31:0] wd;
	wire logic   awr, wr, bv, arr, rv, txp, irq, rxp;
	wire logic [1:0]  br, rr;
	wire logic [31:0] rd;
	int          err_total, checked;

	asp_serial_port u_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .t1_overflow(t1),
		.rx_pin(rxp), .tx_pin(txp), .serial_irq(irq));
	asp_remote_node u_node (.aclk(aclk), .tx_line(txp), .bit_clks(blen), .rx_line(rxp));

	// ----------------------------------------------------------------
	// Clock, timer overflow and reporting
	// ----------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// One-clock overflow pulse every second clock keeps frames short
	always @(posedge aclk) t1 <= aresetn ? ~t1 : 1'b0;

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic end_of_test();
		$display("mismatches %0d, comparisons %0d", err_total, checked);
		if (err_total == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic to();
		err_total++;
		end_of_test();
	endtask

	// ----------------------------------------------------------------
	// Register bus master
	// ----------------------------------------------------------------
	// Address and data offered together; each released once taken
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wr) wv <= 1'b0;
			if (bv) break;
		end
		if (n == 50) to();
		bre <= 1'b0;
		chk(br, er);
	endtask

	task automatic bus_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arv && arr) arv <= 1'b0;
			if (rv) break;
		end
		if (n == 50) to();
		rre <= 1'b0;
		chk(rd, ed);
		chk(rr, er);
	endtask

	task automatic set_ctl(input logic [7:0] v);
		m_ctl = v;
		bus_wr(OFS_CTRL, {24'h0, v}, RESP_OKAY);
	endtask

	// ----------------------------------------------------------------
	// Frame scenarios against the model
	// ----------------------------------------------------------------
	// Send one frame in; model decides whether it may be loaded
	task automatic rx_case(input logic [7:0] d, input logic b9, input logic stp, input int n);
		logic [10:0] f;
		logic        nb;
		f = (n == 10) ? {1'b1, stp, d, 1'b0} : {stp, b9, d, 1'b0};
		nb = (n == 10) ? stp : b9;
		u_node.send(f, n);
		repeat (2 * blen) @(posedge aclk);
		if (m_ctl[4] && !m_ctl[0] && (!m_ctl[5] || nb)) begin
			m_buf = d;
			m_ctl[0] = 1'b1;
			m_ctl[2] = nb;
		end
		bus_rd(OFS_CTRL, {24'h0, m_ctl}, RESP_OKAY);
		bus_rd(OFS_BUF, {24'h0, m_buf}, RESP_OKAY);
		chk(irq, m_ctl[0] | m_ctl[1]);
	endtask

	// Transmit a random byte; frame shape and completion time checked
	task automatic tx_case(input int n);
		logic [7:0]  d;
		logic [10:0] f;
		int          c;
		d = 8'($urandom);
		f = {1'b1, (n == 10) ? 1'b1 : m_ctl[3], d, 1'b0};
		bus_wr(OFS_BUF, {24'h0, d}, RESP_OKAY);
		bus_rd(OFS_STAT, 32'h1, RESP_OKAY);
		for (c = 0; c < 1200 && irq !== 1'b1; c++) @(posedge aclk);
		if (c == 1200) to();
		chk(c > (n - 1) * blen - 16 && c <= n * blen + 16, 1);
		repeat (3 * blen) @(posedge aclk);
		chk(u_node.got_q.size(), 1);
		chk(u_node.got_q.pop_front(), f);
		m_ctl[1] = 1'b1;
		bus_rd(OFS_CTRL, {24'h0, m_ctl}, RESP_OKAY);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		err_total = 0;
		checked = 0;
		{awv, wv, bre, arv, rre, t1} = '0;
		{awa, ara, wd} = '0;
		aresetn = 1'b0;
		blen = 8'd32;
		m_buf = 8'h00;
		void'($urandom(32'hA2F627C4));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(txp, 1);
		bus_rd(OFS_CTRL, {24'h0, CTRL_RST}, RESP_OKAY);
		bus_rd(OFS_BAUD, {31'h0, DBL_RST}, RESP_OKAY);
		bus_rd(8'h10, 32'h0, RESP_SLVERR);
		bus_wr(8'h10, 32'h0, RESP_SLVERR);
		// Ten-bit frames on the doubled timer rate
		bus_wr(OFS_BAUD, 32'h1, RESP_OKAY);
		set_ctl(8'h50);
		tx_case(10);
		set_ctl(8'h51);
		repeat (3) @(posedge aclk);
		chk(irq, 1);
		set_ctl(8'h50);
		repeat (3) @(posedge aclk);
		chk(irq, 0);
		rx_case(8'($urandom), 1'b0, 1'b1, 10);
		rx_case(8'($urandom), 1'b0, 1'b1, 10);
		set_ctl(8'h70);
		rx_case(8'($urandom), 1'b0, 1'b0, 10);
		u_node.glitch(6);
		repeat (2 * blen) @(posedge aclk);
		rx_case(8'($urandom), 1'b0, 1'b1, 10);
		set_ctl(8'h40);
		rx_case(8'($urandom), 1'b0, 1'b1, 10);
		// Eleven-bit fixed rate, slow then doubled
		bus_wr(OFS_BAUD, 32'h0, RESP_OKAY);
		blen = 8'd64;
		set_ctl(8'h88);
		tx_case(11);
		bus_wr(OFS_BAUD, 32'h1, RESP_OKAY);
		blen = 8'd32;
		set_ctl(8'h90);
		tx_case(11);
		set_ctl(8'hB0);
		rx_case(8'($urandom), 1'b0, 1'b1, 11);
		rx_case(8'($urandom), 1'b1, 1'b0, 11);
		// Eleven-bit timer rate, undoubled
		bus_wr(OFS_BAUD, 32'h0, RESP_OKAY);
		blen = 8'd64;
		set_ctl(8'hD8);
		tx_case(11);
		set_ctl(8'hD0);
		rx_case(8'($urandom), 1'b0, 1'b1, 11);
		end_of_test();
	end
endmodule
